// File: odpc_ctrl.sv
`timescale 1ns/1ns
module odpc_ctrl #(
  parameter int OSC_DIV = odpc_pkg::OSC_DIV_DEF,
  parameter int RAMP_STEPS = odpc_pkg::RAMP_STEPS_DEF,
  parameter logic [11:0][25:0] PON_TICKS = odpc_pkg::PON_TICKS_DEF,
  parameter logic [3:0][25:0] STEP_TICKS = odpc_pkg::STEP_TICKS_DEF
) (
  input wire logic clk_i, // 125 MHz clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic reg_wr_i, // Register write strobe
  input wire logic reg_rd_i, // Register read strobe
  input wire logic [7:0] reg_addr_i, // Register offset
  input wire logic [7:0] reg_wdata_i, // Write data
  output logic [7:0] reg_rdata_o, // Read data, next cycle
  input wire logic hp_short_i, // Headphone short detected
  input wire logic spk_short_i, // Class-D short detected
  input wire logic sw_pdn_i, // Software power-down request
  output odpc_pkg::odpc_drv_s drv_en_o, // Driver power enables
  output logic [7:0] ramp_step_o, // Current ramp-up step
  output logic [1:0] hp_cm_sel_o, // Common-mode level code
  output logic hp_ilimit_o, // Headphone current limit
  output logic dac_pdn_o // DAC power-down
);

  odpc_pkg::odpc_state_s s;
  odpc_pkg::odpc_state_s next_s;
  odpc_pkg::odpc_drv_s req;
  logic on_page;
  logic [3:0] pon_code;
  logic [25:0] pon_ticks;
  logic [25:0] step_ticks;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  always_comb
  begin
    req.hp_l = s.hp[odpc_pkg::L_BIT];
    req.hp_r = s.hp[odpc_pkg::R_BIT];
    req.spk_l = s.spk[odpc_pkg::L_BIT];
    req.spk_r = s.spk[odpc_pkg::R_BIT];
    on_page = (s.page == odpc_pkg::PAGE_DRV);
    pon_code = s.timing[odpc_pkg::T_PON_LSB +: 4];
    // Reserved codes fall back to no delay rather than garbage
    pon_ticks = (pon_code < odpc_pkg::PON_CODES) ?
      PON_TICKS[pon_code] : 26'h0;
    step_ticks = STEP_TICKS[s.timing[odpc_pkg::T_STEP_LSB +: 2]];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    // Oscillator tick stands in for the internal RC clock
    next_s.tick = 1'b0;
    if (s.div == 8'(OSC_DIV - 1))
    begin
      next_s.div = 8'h00;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.div = s.div + 8'h01;
    end

    if (reg_wr_i)
    begin
      if (reg_addr_i == odpc_pkg::ADDR_PAGE)
        next_s.page = reg_wdata_i;
      else if (on_page)
      begin
        unique case (reg_addr_i)
          odpc_pkg::ADDR_POLICY: next_s.policy = reg_wdata_i;
          odpc_pkg::ADDR_HP: next_s.hp = reg_wdata_i & odpc_pkg::DRV_WMASK;
          odpc_pkg::ADDR_SPK: next_s.spk = reg_wdata_i & odpc_pkg::DRV_WMASK;
          odpc_pkg::ADDR_TIMING: next_s.timing = reg_wdata_i;
          default: next_s.page = s.page;
        endcase
      end
    end

    // Protection must win over a same-cycle software write
    if (spk_short_i && !s.policy[odpc_pkg::POL_SPK_BIT])
    begin
      next_s.spk[odpc_pkg::L_BIT] = 1'b0;
      next_s.spk[odpc_pkg::R_BIT] = 1'b0;
    end
    if (hp_short_i && !s.policy[odpc_pkg::POL_HP_BIT]
        && s.hp[odpc_pkg::HP_ACT_BIT])
    begin
      next_s.hp[odpc_pkg::L_BIT] = 1'b0;
      next_s.hp[odpc_pkg::R_BIT] = 1'b0;
    end
    next_s.ilimit = hp_short_i && !s.hp[odpc_pkg::HP_ACT_BIT];
    next_s.hp_flag = hp_short_i;
    next_s.spk_flag = spk_short_i && (s.en.spk_l || s.en.spk_r);

    // Power-up sequencer shared by all four drivers
    next_s.done = s.done & req;
    unique case (s.seq)
      odpc_pkg::SEQ_IDLE:
        if ((req & ~s.done) != 4'h0)
        begin
          next_s.seq = odpc_pkg::SEQ_DELAY;
          next_s.cnt = pon_ticks;
          next_s.steps = 8'h00;
        end
      odpc_pkg::SEQ_DELAY:
        if (s.cnt == 26'h0)
        begin
          next_s.seq = odpc_pkg::SEQ_RAMP;
          next_s.cnt = step_ticks;
        end
        else if (s.tick)
          next_s.cnt = s.cnt - 26'h1;
      odpc_pkg::SEQ_RAMP:
        if (s.cnt == 26'h0)
        begin
          if (s.steps == 8'(RAMP_STEPS - 1))
          begin
            next_s.done = req;
            next_s.seq = odpc_pkg::SEQ_IDLE;
          end
          else
          begin
            next_s.steps = s.steps + 8'h01;
            next_s.cnt = step_ticks;
          end
        end
        else if (s.tick)
          next_s.cnt = s.cnt - 26'h1;
    endcase
    if (sw_pdn_i)
    begin
      next_s.done = '0;
      next_s.seq = odpc_pkg::SEQ_IDLE;
    end
    next_s.en = req & next_s.done;
    // Ordered mode waits for every amplifier output to read off
    next_s.dac_pdn = sw_pdn_i
      && (!s.timing[odpc_pkg::T_ORDER_BIT] || s.en == '0);

    next_s.rdata = s.rdata;
    if (reg_rd_i)
    begin
      next_s.rdata = 8'h00;
      if (reg_addr_i == odpc_pkg::ADDR_PAGE)
        next_s.rdata = s.page;
      else if (on_page)
      begin
        unique case (reg_addr_i)
          odpc_pkg::ADDR_POLICY: next_s.rdata = s.policy;
          odpc_pkg::ADDR_HP: next_s.rdata = {s.hp[7:1], s.hp_flag};
          odpc_pkg::ADDR_SPK: next_s.rdata = {s.spk[7:1], s.spk_flag};
          odpc_pkg::ADDR_TIMING: next_s.rdata = s.timing;
          default: next_s.rdata = 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s <= '0;
      s.page <= odpc_pkg::RST_PAGE;
      s.policy <= odpc_pkg::RST_POLICY;
      s.hp <= odpc_pkg::RST_HP;
      s.spk <= odpc_pkg::RST_SPK;
      s.timing <= odpc_pkg::RST_TIMING;
      s.seq <= odpc_pkg::SEQ_IDLE;
    end
    else
      s <= next_s;
  end

  assign reg_rdata_o = s.rdata;
  assign drv_en_o = s.en;
  assign ramp_step_o = s.steps;
  assign hp_cm_sel_o = s.hp[odpc_pkg::HP_CM_LSB +: 2];
  assign hp_ilimit_o = s.ilimit;
  assign dac_pdn_o = s.dac_pdn;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence q_idle_pending;
    s.seq == odpc_pkg::SEQ_IDLE && (req & ~s.done) != 4'h0 && !sw_pdn_i;
  endsequence
  sequence q_in_delay;
    s.seq == odpc_pkg::SEQ_DELAY;
  endsequence

  a_spk_short_clear: assert property (
    spk_short_i && !s.policy[odpc_pkg::POL_SPK_BIT]
    |=> !s.spk[odpc_pkg::L_BIT] && !s.spk[odpc_pkg::R_BIT])
    else $error("speaker power bits not cleared on short");
  a_spk_short_keep: assert property (
    spk_short_i && s.policy[odpc_pkg::POL_SPK_BIT] && !reg_wr_i
    |=> $stable(s.spk))
    else $error("speaker power bits changed with keep policy");
  a_hp_short_clear: assert property (
    hp_short_i && !s.policy[odpc_pkg::POL_HP_BIT]
    && s.hp[odpc_pkg::HP_ACT_BIT]
    |=> !s.hp[odpc_pkg::L_BIT] && !s.hp[odpc_pkg::R_BIT])
    else $error("headphone power bits not cleared on short");
  a_hp_ilimit: assert property (
    hp_short_i && !s.hp[odpc_pkg::HP_ACT_BIT] |=> hp_ilimit_o)
    else $error("current limit missing on headphone short");
  a_hp_flag_read: assert property (
    reg_rd_i && on_page && reg_addr_i == odpc_pkg::ADDR_HP
    |=> reg_rdata_o[odpc_pkg::FLAG_BIT] == $past(s.hp_flag))
    else $error("headphone flag read wrong");
  a_spk_flag_valid: assert property (
    s.spk_flag |-> $past(s.en.spk_l || s.en.spk_r))
    else $error("speaker flag set while powered down");
  a_dac_simul: assert property (
    sw_pdn_i && !s.timing[odpc_pkg::T_ORDER_BIT] |=> dac_pdn_o)
    else $error("DAC not powered down with amplifiers");
  a_dac_ordered: assert property (
    dac_pdn_o && $past(s.timing[odpc_pkg::T_ORDER_BIT])
    |-> $past(s.en) == '0)
    else $error("DAC powered down before amplifiers off");
  a_seq_delay_entry: assert property (
    q_idle_pending |=> q_in_delay ##0 s.cnt == $past(pon_ticks))
    else $error("power-on delay not loaded");
  a_en_rise_after_ramp: assert property (
    $rose(s.en.hp_l) |-> $past(s.seq) == odpc_pkg::SEQ_RAMP)
    else $error("driver enabled without power-up sequence");
  a_cm_level: assert property (
    reg_wr_i && on_page && reg_addr_i == odpc_pkg::ADDR_HP
    |=> hp_cm_sel_o == $past(reg_wdata_i[odpc_pkg::HP_CM_LSB +: 2]))
    else $error("common-mode code mismatch");

endmodule // odpc_ctrl

// File: odpc_pkg.sv
package odpc_pkg;

  // ----------------------------------------------------------------
  // Register map, page 1
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PAGE = 8'h00;
  localparam logic [7:0] ADDR_RSVD_LO = 8'h01;
  localparam logic [7:0] ADDR_RSVD_HI = 8'h1D;
  localparam logic [7:0] ADDR_POLICY = 8'h1E;
  localparam logic [7:0] ADDR_HP = 8'h1F;
  localparam logic [7:0] ADDR_SPK = 8'h20;
  localparam logic [7:0] ADDR_TIMING = 8'h21;
  localparam logic [7:0] PAGE_DRV = 8'h01;

  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_POLICY = 8'h00;
  localparam logic [7:0] RST_HP = 8'h04;
  localparam logic [7:0] RST_SPK = 8'h06;
  localparam logic [7:0] RST_TIMING = 8'h3E;
  // Bit 0 of both driver registers is a read-only flag
  localparam logic [7:0] DRV_WMASK = 8'hFE;

  localparam int POL_HP_BIT = 0;
  localparam int POL_SPK_BIT = 1;
  localparam int L_BIT = 7;
  localparam int R_BIT = 6;
  localparam int HP_CM_LSB = 3;
  localparam int HP_ACT_BIT = 1;
  localparam int FLAG_BIT = 0;
  localparam int T_ORDER_BIT = 7;
  localparam int T_PON_LSB = 3;
  localparam int T_STEP_LSB = 1;
  localparam logic [3:0] PON_CODES = 4'hC;

  // ----------------------------------------------------------------
  // Timing: times in tenths of a microsecond, oscillator in kHz
  // ----------------------------------------------------------------
  localparam longint CLK_KHZ = 125000;
  localparam longint OSC_KHZ = 8200;
  localparam int OSC_DIV_DEF = int'(CLK_KHZ / OSC_KHZ);
  localparam int RAMP_STEPS_DEF = 8;

  function automatic logic [25:0] to_ticks(input longint t_tus);
    to_ticks = 26'(t_tus * OSC_KHZ / 64'd10000);
  endfunction

  localparam logic [11:0][25:0] PON_TICKS_DEF = '{
    to_ticks(64'd61000000), to_ticks(64'd30400000),
    to_ticks(64'd30400000), to_ticks(64'd61000),
    to_ticks(64'd3040000), to_ticks(64'd1530000),
    to_ticks(64'd762000), to_ticks(64'd762000),
    to_ticks(64'd15300), to_ticks(64'd1530),
    to_ticks(64'd153), to_ticks(64'd0)};
  localparam logic [3:0][25:0] STEP_TICKS_DEF = '{
    to_ticks(64'd39000), to_ticks(64'd19500),
    to_ticks(64'd9800), to_ticks(64'd0)};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_DELAY = 3'b010,
    SEQ_RAMP = 3'b100
  } odpc_seq_e;

  typedef struct packed {
    logic hp_l;
    logic hp_r;
    logic spk_l;
    logic spk_r;
  } odpc_drv_s;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] policy;
    logic [7:0] hp;
    logic [7:0] spk;
    logic [7:0] timing;
    odpc_seq_e seq;
    logic [7:0] div;
    logic tick;
    logic [25:0] cnt;
    logic [7:0] steps;
    odpc_drv_s done;
    odpc_drv_s en;
    logic hp_flag;
    logic spk_flag;
    logic ilimit;
    logic dac_pdn;
    logic [7:0] rdata;
  } odpc_state_s;

endpackage

// File: test_odpc_ctrl.sv
`timescale 1ns/1ns
module test_odpc_ctrl;
  // ----------------------------------------------------------------
  // Stimulus and design
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic hp_short_i = 1'b0;
  logic spk_short_i = 1'b0;
  logic sw_pdn_i = 1'b0;
  odpc_pkg::odpc_drv_s drv_en_o;
  logic [7:0] ramp_step_o;
  logic [1:0] hp_cm_sel_o;
  logic hp_ilimit_o;
  logic dac_pdn_o;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] rd;

  always #4 clk_i = ~clk_i;

  // Short counts keep a full power-up near twenty clocks
  odpc_ctrl #(
    .OSC_DIV(2),
    .RAMP_STEPS(2),
    .PON_TICKS('{default: 26'h3}),
    .STEP_TICKS('{default: 26'h2})
  ) u_odpc_ctrl (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .hp_short_i(hp_short_i),
    .spk_short_i(spk_short_i),
    .sw_pdn_i(sw_pdn_i),
    .drv_en_o(drv_en_o),
    .ramp_step_o(ramp_step_o),
    .hp_cm_sel_o(hp_cm_sel_o),
    .hp_ilimit_o(hp_ilimit_o),
    .dac_pdn_o(dac_pdn_o)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, exp, mask);
    n_tests++;
    if ((got & mask) !== (exp & mask))
    begin
      n_errors++;
      $display("CHECK FAILED %0t reg %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t pin %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    #1 reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge clk_i);
    #1 reg_wr_i = 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, exp, mask);
    @(posedge clk_i);
    #1 reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(posedge clk_i);
    #1 reg_rd_i = 1'b0;
    chk_reg(reg_rdata_o, exp, mask);
  endtask

  task automatic wait_en(input logic [3:0] exp);
    int i;
    i = 0;
    while (4'(drv_en_o) !== exp && i < 300)
    begin
      @(posedge clk_i);
      #1 i++;
    end
    chk_pin({4'h0, 4'(drv_en_o)}, {4'h0, exp});
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    rdc(8'h1F, 8'h00, 8'hFF);
    wr(8'h00, 8'h01);
    rdc(8'h00, 8'h01, 8'hFF);
    rdc(8'h1E, 8'h00, 8'hFF);
    rdc(8'h1F, 8'h04, 8'hFF);
    rdc(8'h20, 8'h06, 8'hFF);
    rdc(8'h21, 8'h3E, 8'hFF);
    chk_pin(ramp_step_o, 8'h00);
    // Other pages must not reach the driver bank
    wr(8'h00, 8'h02);
    wr(8'h1F, 8'hC6);
    rdc(8'h1F, 8'h00, 8'hFF);
    wr(8'h00, 8'h01);
    rdc(8'h1F, 8'h04, 8'hFF);
    rdc(8'h05, 8'h00, 8'hFF);
    $display("test reset_map done");
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h1F, {3'h0, 2'(c), 3'h4});
      cyc_n(1);
      chk_pin({6'h00, hp_cm_sel_o}, 8'(c));
    end
    $display("test common_mode done");
    wr(8'h21, 8'h00);
    wr(8'h1F, 8'hC6);
    wait_en(4'hC);
    chk_pin(ramp_step_o, 8'h01);
    hp_short_i = 1'b1;
    cyc_n(3);
    rdc(8'h1F, 8'h07, 8'hFF);
    wait_en(4'h0);
    hp_short_i = 1'b0;
    cyc_n(2);
    rdc(8'h1F, 8'h06, 8'hFF);
    wr(8'h1F, 8'hC4);
    wait_en(4'hC);
    hp_short_i = 1'b1;
    cyc_n(3);
    chk_pin({7'h00, hp_ilimit_o}, 8'h01);
    chk_pin({4'h0, 4'(drv_en_o)}, 8'h0C);
    hp_short_i = 1'b0;
    cyc_n(2);
    chk_pin({7'h00, hp_ilimit_o}, 8'h00);
    wr(8'h1E, 8'h01);
    wr(8'h1F, 8'hC6);
    hp_short_i = 1'b1;
    cyc_n(3);
    rdc(8'h1F, 8'hC7, 8'hFF);
    hp_short_i = 1'b0;
    wr(8'h1F, 8'h04);
    wait_en(4'h0);
    $display("test headphone done");
    wr(8'h1E, 8'h00);
    wr(8'h20, 8'hC6);
    wait_en(4'h3);
    spk_short_i = 1'b1;
    cyc_n(3);
    // Flag must read 0 once the class-D pair is off
    rdc(8'h20, 8'h06, 8'hFF);
    spk_short_i = 1'b0;
    wait_en(4'h0);
    wr(8'h1E, 8'h02);
    wr(8'h20, 8'hC6);
    wait_en(4'h3);
    spk_short_i = 1'b1;
    cyc_n(3);
    rdc(8'h20, 8'hC7, 8'hFF);
    spk_short_i = 1'b0;
    $display("test speaker done");
    // Power-down ordering, both settings of the order bit
    sw_pdn_i = 1'b1;
    cyc_n(1);
    chk_pin({7'h00, dac_pdn_o}, 8'h01);
    sw_pdn_i = 1'b0;
    wr(8'h21, 8'h80);
    wr(8'h20, 8'h06);
    wr(8'h1F, 8'hC4);
    cyc_n(2);
    wr(8'h20, 8'hC6);
    wait_en(4'hF);
    sw_pdn_i = 1'b1;
    cyc_n(1);
    chk_pin({4'h0, 4'(drv_en_o)}, 8'h00);
    chk_pin({7'h00, dac_pdn_o}, 8'h00);
    cyc_n(1);
    chk_pin({7'h00, dac_pdn_o}, 8'h01);
    sw_pdn_i = 1'b0;
    $display("test power_down done");
    end_of_test();
  end
endmodule // test_odpc_ctrl
